// file: common/fcc_pkg.sv
// Package with register map, field layout, command codes and timing for the flash command controller.
package fcc_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] FCC_MODE_OFS    = 8'h60;
   localparam logic [7:0] FCC_COMMAND_OFS = 8'h64;
   localparam logic [7:0] FCC_STATUS_OFS  = 8'h68;
   localparam logic [7:0] FCC_RSVD_OFS    = 8'h6C;
   localparam logic [7:0] FCC_CTRL_OFS    = 8'h70;
   localparam logic [31:0] FCC_MODE_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int FCC_BIT_READY    = 0;
   localparam int FCC_BIT_LOCKERR  = 2;
   localparam int FCC_BIT_BADCMD   = 3;
   localparam int FCC_BIT_SECURE   = 4;
   localparam int FCC_BIT_SKIP     = 7;
   localparam int FCC_WS_LSB       = 8;
   localparam int FCC_CPU_LSB      = 16;
   localparam int FCC_GP_LSB       = 8;
   localparam int FCC_LOCKS_LSB    = 16;
   localparam int FCC_KEY_LSB      = 24;
   localparam int FCC_PAGE_LSB     = 8;
   localparam int FCC_CMD_LSB      = 0;
   localparam logic [7:0] FCC_KEY  = 8'h5A;

   // ---------------------------------------------------------------
   // Sizes and timing
   // ---------------------------------------------------------------
   localparam int FCC_NUM_GP       = 2;
   localparam int FCC_NUM_REGIONS  = 8;
   localparam int FCC_PAGES_PER_RG = 32;
   localparam int FCC_PROG_US      = 4;
   localparam int FCC_ERASE_US     = 10;
   localparam int FCC_NVM_US       = 1;
   localparam int FCC_WIPE_DELAY   = 16;

   // ---------------------------------------------------------------
   // Commands, states and carriers
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      FCC_CMD_NONE   = 4'h0,
      FCC_CMD_WRITE  = 4'h1,
      FCC_CMD_LOCK   = 4'h2,
      FCC_CMD_WLOCK  = 4'h3,
      FCC_CMD_UNLOCK = 4'h4,
      FCC_CMD_WIPE   = 4'h8,
      FCC_CMD_GPSET  = 4'hB,
      FCC_CMD_GPCLR  = 4'hD,
      FCC_CMD_SECURE = 4'hF
   } fcc_cmd_e;

   typedef enum logic [4:0] {
      FCC_ST_IDLE  = 5'b00001,
      FCC_ST_ERASE = 5'b00010,
      FCC_ST_PROG  = 5'b00100,
      FCC_ST_NVM   = 5'b01000,
      FCC_ST_XWIPE = 5'b10000
   } fcc_state_e;

   typedef struct packed {
      logic        skip_page_erase;
      logic [1:0]  wait_state_count;
      logic [7:0]  cycles_per_microsecond;
      logic [3:0]  irq_enable;
   } fcc_mode_s;

   typedef struct packed {
      logic [7:0]  key;
      logic [9:0]  page_index;
      logic [3:0]  command_code;
   } fcc_command_s;

endpackage

// file: rtl/fcc_us_tick.sv
// Microsecond tick divider driven by the programmed cycles-per-microsecond value.
`timescale 1ns/1ps
`default_nettype none
module fcc_us_tick
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       run,
   input  wire logic [7:0] cycles_per_microsecond,
   output logic            tick
);
   logic [7:0] count_r;

   // ---------------------------------------------------------------
   // Divider
   // ---------------------------------------------------------------
   // A zero setting ticks every cycle, which suits very slow clocks.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         count_r <= 8'h00;
      else if (!run || count_r + 8'h01 >= cycles_per_microsecond)
         count_r <= 8'h00;
      else
         count_r <= count_r + 8'h01;
   end

   assign tick = run && (count_r + 8'h01 >= cycles_per_microsecond);
endmodule
`default_nettype wire

// file: rtl/fcc_top.sv
// Flash command controller: mode, command and status registers with operation sequencing.
`timescale 1ns/1ps
`default_nettype none
module fcc_top
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic [31:0]      reg_rdata,
   input  wire logic        erase_pin,
   output logic             irq,
   output logic             debug_port_enable,
   output logic             read_access_allowed,
   output logic [1:0]       read_cycles_m1,
   output logic [1:0]       write_cycles_m1,
   output logic             array_erase_page,
   output logic             array_program_page,
   output logic             array_erase_all,
   output logic [9:0]       array_page
);
   fcc_pkg::fcc_mode_s    mode_r;
   fcc_pkg::fcc_command_s cmd_in;
   fcc_pkg::fcc_state_e   state_r;
   fcc_pkg::fcc_state_e   state_nxt;
   logic                         ready_r;
   logic                         lock_err_r;
   logic                         bad_cmd_r;
   logic                         secure_r;
   logic [fcc_pkg::FCC_NUM_GP-1:0]      gp_cell_r;
   logic [fcc_pkg::FCC_NUM_REGIONS-1:0] lock_cell_r;
   logic [3:0]                   op_code_r;
   logic [9:0]                   op_page_r;
   logic [7:0]                   us_left_r;
   logic [2:0]                   pin_sync_r;
   logic                         pin_level_r;
   logic                         pin_rise;
   logic                         tick;
   logic                         cmd_write;
   logic                         status_read;
   logic                         key_ok;
   logic                         code_ok;
   logic                         accept;
   logic                         op_done;
   logic                         region_locked;
   logic [2:0]                   op_region;
   logic [31:0]                  status_word;
   logic [31:0]                  mode_word;

   // ---------------------------------------------------------------
   // Decoding helpers
   // ---------------------------------------------------------------
   function automatic logic code_defined(input logic [3:0] code);
      case (code)
         fcc_pkg::FCC_CMD_WRITE,
         fcc_pkg::FCC_CMD_LOCK,
         fcc_pkg::FCC_CMD_WLOCK,
         fcc_pkg::FCC_CMD_UNLOCK,
         fcc_pkg::FCC_CMD_WIPE,
         fcc_pkg::FCC_CMD_GPSET,
         fcc_pkg::FCC_CMD_GPCLR,
         fcc_pkg::FCC_CMD_SECURE:
            code_defined = 1'b1;
         default:
            code_defined = 1'b0;
      endcase
   endfunction

   function automatic logic [2:0] region_of(input logic [9:0] page);
      region_of = 3'(page / 10'(fcc_pkg::FCC_PAGES_PER_RG));
   endfunction

   function automatic logic [7:0] delay_of(input logic [3:0] code);
      case (code)
         fcc_pkg::FCC_CMD_WIPE:
            delay_of = 8'(fcc_pkg::FCC_ERASE_US);
         fcc_pkg::FCC_CMD_WRITE,
         fcc_pkg::FCC_CMD_WLOCK:
            delay_of = 8'(fcc_pkg::FCC_PROG_US);
         default:
            delay_of = 8'(fcc_pkg::FCC_NVM_US);
      endcase
   endfunction

   assign cmd_in      = {reg_wdata[31:24], reg_wdata[17:8], reg_wdata[3:0]};
   assign cmd_write   = reg_write && reg_addr == fcc_pkg::FCC_COMMAND_OFS;
   assign status_read = reg_read && reg_addr == fcc_pkg::FCC_STATUS_OFS;
   assign key_ok      = cmd_in.key == fcc_pkg::FCC_KEY;
   assign code_ok     = code_defined(cmd_in.command_code);
   // Commands written while busy are dropped; software waits for ready.
   assign accept      = cmd_write && key_ok && code_ok && state_r == fcc_pkg::FCC_ST_IDLE;
   assign op_region   = region_of(op_page_r);
   assign region_locked = ~lock_cell_r[op_region];

   // ---------------------------------------------------------------
   // Erase pin synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         pin_sync_r <= 3'b000;
      else
         pin_sync_r <= {pin_sync_r[1:0], erase_pin};
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         pin_level_r <= 1'b0;
      else if (pin_sync_r[1] == pin_sync_r[2])
         pin_level_r <= pin_sync_r[2];
   end

   assign pin_rise = pin_sync_r[1] && pin_sync_r[2] && !pin_level_r;

   // ---------------------------------------------------------------
   // Mode register
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         mode_r <= fcc_pkg::fcc_mode_s'(15'(fcc_pkg::FCC_MODE_RESET));
      else if (reg_write && reg_addr == fcc_pkg::FCC_MODE_OFS)
      begin
         mode_r.skip_page_erase        <= reg_wdata[fcc_pkg::FCC_BIT_SKIP];
         mode_r.wait_state_count       <= reg_wdata[fcc_pkg::FCC_WS_LSB +: 2];
         mode_r.cycles_per_microsecond <= reg_wdata[fcc_pkg::FCC_CPU_LSB +: 8];
         mode_r.irq_enable             <= {reg_wdata[3:2], 1'b0, reg_wdata[0]};
      end
   end

   assign read_cycles_m1  = mode_r.wait_state_count;
   assign write_cycles_m1 = (mode_r.wait_state_count == 2'd3) ? 2'd3 : mode_r.wait_state_count + 2'd1;

   // ---------------------------------------------------------------
   // Microsecond timing
   // ---------------------------------------------------------------
   fcc_us_tick fcc_us_tick_inst
   (
      .clock                  (clock),
      .reset_n                (reset_n),
      .run                    (state_r != fcc_pkg::FCC_ST_IDLE),
      .cycles_per_microsecond (mode_r.cycles_per_microsecond),
      .tick                   (tick)
   );

   assign op_done = tick && us_left_r == 8'd1;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         fcc_pkg::FCC_ST_IDLE:
            if (pin_rise)
               state_nxt = fcc_pkg::FCC_ST_XWIPE;
            else if (accept)
            begin
               case (cmd_in.command_code)
                  fcc_pkg::FCC_CMD_WRITE,
                  fcc_pkg::FCC_CMD_WLOCK:
                     state_nxt = mode_r.skip_page_erase ? fcc_pkg::FCC_ST_PROG : fcc_pkg::FCC_ST_ERASE;
                  fcc_pkg::FCC_CMD_WIPE:
                     state_nxt = fcc_pkg::FCC_ST_ERASE;
                  default:
                     state_nxt = fcc_pkg::FCC_ST_NVM;
               endcase
            end
         fcc_pkg::FCC_ST_ERASE:
            if (op_done)
               state_nxt = (op_code_r == fcc_pkg::FCC_CMD_WIPE) ? fcc_pkg::FCC_ST_IDLE : fcc_pkg::FCC_ST_PROG;
         fcc_pkg::FCC_ST_PROG,
         fcc_pkg::FCC_ST_NVM,
         fcc_pkg::FCC_ST_XWIPE:
            if (op_done)
               state_nxt = fcc_pkg::FCC_ST_IDLE;
         default:
            state_nxt = fcc_pkg::FCC_ST_IDLE;
      endcase
      // Locked targets cancel the operation before it touches the array.
      if (state_r == fcc_pkg::FCC_ST_ERASE || state_r == fcc_pkg::FCC_ST_PROG)
      begin
         if (op_code_r == fcc_pkg::FCC_CMD_WIPE ? lock_cell_r != '1 : region_locked)
            state_nxt = fcc_pkg::FCC_ST_IDLE;
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         state_r <= fcc_pkg::FCC_ST_IDLE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         op_code_r <= 4'h0;
         op_page_r <= 10'h000;
         us_left_r <= 8'h00;
      end
      else if (state_r == fcc_pkg::FCC_ST_IDLE && pin_rise)
         us_left_r <= 8'(fcc_pkg::FCC_WIPE_DELAY);
      else if (accept)
      begin
         op_code_r <= cmd_in.command_code;
         op_page_r <= cmd_in.page_index;
         us_left_r <= delay_of(cmd_in.command_code);
      end
      else if (state_nxt != state_r && state_nxt == fcc_pkg::FCC_ST_PROG)
         us_left_r <= 8'(fcc_pkg::FCC_PROG_US);
      else if (tick && us_left_r != 8'h00)
         us_left_r <= us_left_r - 8'h01;
   end

   // ---------------------------------------------------------------
   // Nonvolatile bits
   // ---------------------------------------------------------------
   // Cells are modelled as flops erased to one; a real part reloads them from the array.
   generate
      for (genvar g = 0; g < fcc_pkg::FCC_NUM_GP; g++)
      begin : g_gp
         always_ff @(posedge clock or negedge reset_n)
         begin
            if (!reset_n)
               gp_cell_r[g] <= 1'b1;
            else if (state_r == fcc_pkg::FCC_ST_XWIPE && op_done)
               gp_cell_r[g] <= 1'b1;
            else if (state_r == fcc_pkg::FCC_ST_NVM && op_done && op_page_r == 10'(g))
            begin
               if (op_code_r == fcc_pkg::FCC_CMD_GPSET)
                  gp_cell_r[g] <= 1'b0;
               else if (op_code_r == fcc_pkg::FCC_CMD_GPCLR)
                  gp_cell_r[g] <= 1'b1;
            end
         end
      end
      for (genvar r = 0; r < fcc_pkg::FCC_NUM_REGIONS; r++)
      begin : g_lock
         always_ff @(posedge clock or negedge reset_n)
         begin
            if (!reset_n)
               lock_cell_r[r] <= 1'b1;
            else if (state_r == fcc_pkg::FCC_ST_XWIPE && op_done)
               lock_cell_r[r] <= 1'b1;
            else if (op_done && op_region == 3'(r))
            begin
               if (state_r == fcc_pkg::FCC_ST_NVM && op_code_r == fcc_pkg::FCC_CMD_LOCK)
                  lock_cell_r[r] <= 1'b0;
               else if (state_r == fcc_pkg::FCC_ST_NVM && op_code_r == fcc_pkg::FCC_CMD_UNLOCK)
                  lock_cell_r[r] <= 1'b1;
               else if (state_r == fcc_pkg::FCC_ST_PROG && op_code_r == fcc_pkg::FCC_CMD_WLOCK)
                  lock_cell_r[r] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         secure_r <= 1'b0;
      else if (state_r == fcc_pkg::FCC_ST_XWIPE && op_done)
         secure_r <= 1'b0;
      else if (state_r == fcc_pkg::FCC_ST_NVM && op_done && op_code_r == fcc_pkg::FCC_CMD_SECURE)
         secure_r <= 1'b1;
   end

   assign debug_port_enable   = !secure_r;
   assign read_access_allowed = state_r != fcc_pkg::FCC_ST_ERASE && state_r != fcc_pkg::FCC_ST_PROG
                                && state_r != fcc_pkg::FCC_ST_XWIPE;
   assign array_erase_page    = state_r == fcc_pkg::FCC_ST_ERASE && op_code_r != fcc_pkg::FCC_CMD_WIPE
                                && !region_locked;
   assign array_program_page  = state_r == fcc_pkg::FCC_ST_PROG && !region_locked;
   assign array_erase_all     = state_r == fcc_pkg::FCC_ST_XWIPE
                                || (state_r == fcc_pkg::FCC_ST_ERASE && op_code_r == fcc_pkg::FCC_CMD_WIPE
                                    && lock_cell_r == '1);
   assign array_page          = op_page_r;

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         ready_r <= 1'b1;
      else if (accept || (state_r == fcc_pkg::FCC_ST_IDLE && pin_rise))
         ready_r <= 1'b0;
      else if (state_r != fcc_pkg::FCC_ST_IDLE && state_nxt == fcc_pkg::FCC_ST_IDLE)
         ready_r <= 1'b1;
   end

   // Setting wins over the clear-on-read in the same cycle.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         bad_cmd_r <= 1'b0;
      else if (cmd_write && (!key_ok || (!code_ok && cmd_in.command_code != 4'h0)))
         bad_cmd_r <= 1'b1;
      else if (status_read)
         bad_cmd_r <= 1'b0;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         lock_err_r <= 1'b0;
      else if ((state_r == fcc_pkg::FCC_ST_ERASE || state_r == fcc_pkg::FCC_ST_PROG)
               && (op_code_r == fcc_pkg::FCC_CMD_WIPE ? lock_cell_r != '1 : region_locked))
         lock_err_r <= 1'b1;
      else if (status_read)
         lock_err_r <= 1'b0;
   end

   assign irq = (ready_r && mode_r.irq_enable[0]) || (lock_err_r && mode_r.irq_enable[2])
                || (bad_cmd_r && mode_r.irq_enable[3]);

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[fcc_pkg::FCC_BIT_READY]   = ready_r;
      status_word[fcc_pkg::FCC_BIT_LOCKERR] = lock_err_r;
      status_word[fcc_pkg::FCC_BIT_BADCMD]  = bad_cmd_r;
      status_word[fcc_pkg::FCC_BIT_SECURE]  = secure_r;
      status_word[fcc_pkg::FCC_GP_LSB +: fcc_pkg::FCC_NUM_GP]         = ~gp_cell_r;
      status_word[fcc_pkg::FCC_LOCKS_LSB +: fcc_pkg::FCC_NUM_REGIONS] = ~lock_cell_r;
      mode_word = 32'h0000_0000;
      mode_word[fcc_pkg::FCC_BIT_SKIP]        = mode_r.skip_page_erase;
      mode_word[fcc_pkg::FCC_WS_LSB +: 2]     = mode_r.wait_state_count;
      mode_word[fcc_pkg::FCC_CPU_LSB +: 8]    = mode_r.cycles_per_microsecond;
      mode_word[3:0]                          = mode_r.irq_enable;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= 32'h0000_0000;
      else if (reg_read && reg_addr == fcc_pkg::FCC_MODE_OFS)
         reg_rdata <= mode_word;
      else if (status_read)
         reg_rdata <= status_word;
      else
         reg_rdata <= 32'h0000_0000;
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_busy_after_cmd: assert property (@(posedge clock) disable iff (!reset_n)
      accept |=> !ready_r) else $error("ready not cleared by command");
   a_bad_key_flag: assert property (@(posedge clock) disable iff (!reset_n)
      (cmd_write && !key_ok) |=> bad_cmd_r) else $error("bad key not flagged");
   a_bad_key_idle: assert property (@(posedge clock) disable iff (!reset_n)
      (cmd_write && !key_ok && state_r == fcc_pkg::FCC_ST_IDLE && !pin_rise) |=> state_r == fcc_pkg::FCC_ST_IDLE)
      else $error("bad key started work");
   a_nop_quiet: assert property (@(posedge clock) disable iff (!reset_n)
      (cmd_write && key_ok && cmd_in.command_code == 4'h0 && !bad_cmd_r) |=> !bad_cmd_r)
      else $error("no-op raised error");
   a_flag_on_read: assert property (@(posedge clock) disable iff (!reset_n)
      (status_read && !cmd_write) |=> !bad_cmd_r) else $error("error flag not cleared");
   a_secure_sticky: assert property (@(posedge clock) disable iff (!reset_n)
      ($fell(secure_r)) |-> $past(state_r) == fcc_pkg::FCC_ST_XWIPE) else $error("security cleared by command");
   a_secure_ports: assert property (@(posedge clock) disable iff (!reset_n)
      secure_r |-> !debug_port_enable) else $error("ports open while secure");
   a_irq_masked: assert property (@(posedge clock) disable iff (!reset_n)
      (mode_r.irq_enable == 4'h0) |-> !irq) else $error("irq without enable");
   a_gp_set_done: assert property (@(posedge clock) disable iff (!reset_n)
      (accept && cmd_in.command_code == fcc_pkg::FCC_CMD_GPSET && cmd_in.page_index == 10'd0
       && mode_r.cycles_per_microsecond == 8'd1 && !pin_rise) |-> ##2 !gp_cell_r[0])
      else $error("gp set not applied");
   a_wait_write: assert property (@(posedge clock) disable iff (!reset_n)
      (mode_r.wait_state_count == 2'd3) |-> write_cycles_m1 == 2'd3) else $error("write cycles wrong");
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking testbench for the flash command controller register port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clock = 0, reset_n = 0, reg_write = 0, reg_read = 0, erase_pin = 0, rd_d = 0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rv;
   logic        irq, dbg, rda, er, pg, ea;
   logic [1:0]  rc, wc;
   logic [9:0]  ap;
   logic [63:0] exp_q[$];
   logic [3:0]  rsv[7] = '{4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hC, 4'hE};
   int          miscompares = 0, n_tests = 0, n_er = 0, n_pg = 0, n_ea = 0, er_mark = 0;
   localparam logic [7:0] MD = fcc_pkg::FCC_MODE_OFS, CM = fcc_pkg::FCC_COMMAND_OFS, ST = fcc_pkg::FCC_STATUS_OFS;
   fcc_top fcc_top_inst (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .erase_pin(erase_pin), .irq(irq),
      .debug_port_enable(dbg), .read_access_allowed(rda), .read_cycles_m1(rc), .write_cycles_m1(wc),
      .array_erase_page(er), .array_program_page(pg), .array_erase_all(ea), .array_page(ap));
   initial forever #5 clock = ~clock;
   task automatic chk(input logic ok);
      n_tests++;
      if (!ok)
      begin
         miscompares++;
         $display("Error at %0t: value mismatch", $time);
      end
   endtask
   always @(posedge clock) rd_d <= reg_read;
   // Array strobes last only a few cycles, so their cycles are counted and compared afterwards.
   always @(posedge clock) if (er === 1'b1) n_er <= n_er + 1;
   always @(posedge clock) if (pg === 1'b1) n_pg <= n_pg + 1;
   always @(posedge clock) if (ea === 1'b1) n_ea <= n_ea + 1;
   always @(negedge clock)
      if (rd_d)
      begin
         chk((reg_rdata & exp_q[0][63:32]) === (exp_q[0][31:0] & exp_q[0][63:32]));
         void'(exp_q.pop_front());
      end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      exp_q.push_back({m, v});
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
   endtask
   task automatic cmd(input logic [7:0] k, input logic [9:0] p, input logic [3:0] c);
      wr(CM, {k, 6'h00, p, 4'h0, c});
   endtask
   // Polling reads clear the error flags, so error checks wait a fixed span instead.
   task automatic wait_rdy;
      repeat (300)
         if (reg_rdata[0] !== 1'b1)
            rd(ST, 32'h0000_0000, 32'h0000_0000);
      chk(reg_rdata[0] === 1'b1);
   endtask
   task automatic op(input logic [7:0] k, input logic [9:0] p, input logic [3:0] c);
      cmd(k, p, c);
      wait_rdy;
   endtask
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clock);
      miscompares++;
      complete_run;
   end
   initial
   begin
      void'($urandom(32'haf8e));
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      rd(MD, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(ST, 32'hFFFF_FFFF, 32'h0000_0001);
      rd(fcc_pkg::FCC_RSVD_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
      rv = $urandom;
      wr(MD, rv);
      rd(MD, 32'hFFFF_FFFF, rv & 32'h00FF_038D);
      for (int w = 0; w < 4; w++)
      begin
         wr(MD, 32'h0001_0000 | (32'(w) << 8));
         repeat (2) @(negedge clock);
         chk(rc === 2'(w) && wc === ((w == 3) ? 2'd3 : 2'(w + 1)));
      end
      cmd(8'h5A, 10'd0, 4'hB);
      @(negedge clock);
      chk(rda === 1'b1);
      wait_rdy;
      rd(ST, 32'h0000_0301, 32'h0000_0101);
      op(8'h5A, 10'd2, 4'hB);
      rd(ST, 32'h0000_0300, 32'h0000_0100);
      op(8'h5A, 10'd1, 4'hB);
      op(8'h5A, 10'd0, 4'hD);
      rd(ST, 32'h0000_0300, 32'h0000_0200);
      wr(MD, 32'h0001_0008);
      cmd(8'h12, 10'd1, 4'hD);
      repeat (2) @(negedge clock);
      chk(irq === 1'b1);
      rd(ST, 32'h0000_030C, 32'h0000_0208);
      chk(irq === 1'b0);
      rd(ST, 32'h0000_0008, 32'h0000_0000);
      foreach (rsv[i])
      begin
         cmd(8'h5A, 10'd0, rsv[i]);
         rd(ST, 32'h0000_0008, 32'h0000_0008);
      end
      cmd(8'h5A, 10'd0, 4'h0);
      rd(ST, 32'h0000_0008, 32'h0000_0000);
      wr(MD, 32'h0001_0080);
      er_mark = n_er;
      op(8'h5A, 10'd40, 4'h1);
      chk(n_er == er_mark);
      wr(MD, 32'h0001_0000);
      cmd(8'h5A, 10'd41, 4'h1);
      rd(ST, 32'h0000_0001, 32'h0000_0000);
      chk(er === 1'b1 && ap === 10'd41);
      wait_rdy;
      chk(n_er > er_mark);
      op(8'h5A, 10'd40, 4'h2);
      rd(ST, 32'h00FF_0000, 32'h0002_0000);
      cmd(8'h5A, 10'd33, 4'h1);
      repeat (6) @(negedge clock);
      rd(ST, 32'h0000_0005, 32'h0000_0005);
      cmd(8'h5A, 10'd0, 4'h8);
      repeat (6) @(negedge clock);
      rd(ST, 32'h0000_0005, 32'h0000_0005);
      op(8'h5A, 10'd63, 4'h4);
      op(8'h5A, 10'd70, 4'h3);
      rd(ST, 32'h00FF_0000, 32'h0004_0000);
      op(8'h5A, 10'd0, 4'hF);
      chk(dbg === 1'b0);
      op(8'h5A, 10'd0, 4'hD);
      rd(ST, 32'h0000_0010, 32'h0000_0010);
      @(posedge clock);
      erase_pin <= 1'b1;
      repeat (8) @(posedge clock);
      erase_pin <= 1'b0;
      rd(ST, 32'h0000_0011, 32'h0000_0010);
      wait_rdy;
      rd(ST, 32'hFFFF_FFFF, 32'h0000_0001);
      chk(dbg === 1'b1);
      chk(n_ea == fcc_pkg::FCC_WIPE_DELAY);
      chk(n_pg == 3 * fcc_pkg::FCC_PROG_US);
      complete_run;
   end
endmodule
`default_nettype wire
